//--- pkg/tcs_map.svh
// offsets, field positions and reset values of the transfer status block
// assumes a 32-bit axi4-lite register bus with byte addresses
`ifndef TCS_MAP_SVH
`define TCS_MAP_SVH

// register byte offsets
`define TCS_OFS_CHAN_STAT 8'h00
`define TCS_OFS_ERR_STAT  8'h04
`define TCS_OFS_ERR_EN    8'h08
`define TCS_OFS_ERR_CLR   8'h0C
`define TCS_OFS_ERR_DET   8'h10
`define TCS_OFS_ERR_CMD   8'h14
`define TCS_OFS_EVT_STAT  8'h18
`define TCS_OFS_EVT_MASK  8'h1C
`define TCS_OFS_LAST      8'h1C

// channel status fields
`define TCS_CS_PROG_BIT   0
`define TCS_CS_SRC_BIT    1
`define TCS_CS_WSP_BIT    2
`define TCS_CS_OCC_LSB    4
`define TCS_CS_ONE_BIT    8

// error status, enable and clear fields
`define TCS_ES_BUS_BIT    0
`define TCS_ES_REQ_BIT    2
`define TCS_ES_ADDR_BIT   3
`define TCS_ES_MASK       4'hD
`define TCS_ERR_EN_RST    4'h0

// error command and event fields
`define TCS_CMD_ERROR_REEVALUATE_BIT  0
`define TCS_EV_MOVE_BIT   0
`define TCS_EV_DONE_BIT   1
`define TCS_EV_ERR_BIT    2
`define TCS_EVT_MASK_RST  3'h0

// documented destination fifo depth and fifo-mode alignment
`define TCS_DEST_DEPTH    4
`define TCS_ALIGN_BITS    5
`endif

//--- pkg/tcs_pkg.sv
// types shared by the transfer status block
// assumes the constants of tcs_map.svh
package tcs_pkg;
   // program set occupancy
   typedef enum logic [0:0] {
      TCS_PS_IDLE = 1'b0,
      TCS_PS_HELD = 1'b1
   } tcs_prog_state_type;
   // axi response codes used here
   typedef enum logic [1:0] {
      TCS_RESP_OKAY   = 2'b00,
      TCS_RESP_SLVERR = 2'b10
   } tcs_resp_type;
endpackage

//--- rtl/tcs_dest_occ.sv
// occupancy count of the destination request fifo
// assumes push and pop come from logic on the same clock
`timescale 1ns/1ns
`include "tcs_map.svh"
module tcs_dest_occ #(
   parameter int DEPTH = `TCS_DEST_DEPTH,
   parameter int OCC_W = 3
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             push,
   input  wire logic             pop,
   output logic      [OCC_W-1:0] occ,
   output logic                  full,
   output logic                  empty
);
   logic [OCC_W-1:0] occ_reg;
   logic             push_ok;
   logic             pop_ok;

   // no entry while full, no removal while empty
   assign push_ok = push & ~full; // see RULE4
   assign pop_ok  = pop & ~empty;
   assign full    = (occ_reg == OCC_W'(DEPTH));
   assign empty   = (occ_reg == '0);
   assign occ     = occ_reg;

   // count resident requests, never above depth
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         occ_reg <= '0;
      end else if (push_ok && !pop_ok) begin
         occ_reg <= occ_reg + OCC_W'(1); // see RULE1
      end else if (pop_ok && !push_ok) begin
         occ_reg <= occ_reg - OCC_W'(1); // see RULE4
      end
   end
endmodule // tcs_dest_occ

//--- rtl/tcs_status_top.sv
// channel status, error status and error interrupt of a transfer controller
// assumes datapath events and requests come from logic on aclk
// Function
// RULE1: occupancy field counts resident requests 0..4; codes 5..7 never occur
// RULE2: request in program set moves to empty destination fifo at once
// RULE3: partly filled fifo takes the request only while source engine idles
// RULE4: full fifo takes nothing until its head request completes
// RULE5: status bit 2 high while any issued write awaits its status
// RULE6: status bit 1 high while the source engine services a request
// RULE7: status bit 0 low when program set free; controller programs then only
// RULE8: access to an unmapped register sets error status bit 3
// RULE9: zero count or fifo-mode misalignment in a request sets error bit 2
// RULE10: nonzero bus status sets error bit 0 and fills error details
// RULE11: enable bits 3, 2, 0 gate their status bits onto error interrupt
// RULE12: error status and enable bits 31..4 and 1 read zero
// RULE13: writing 1 to clear bit 0 clears bus error and details
// RULE14: error evaluate re-pulses the error line while any error stands
// RULE15: occupancy field sits in channel status bits 6..4
// RULE16: error line is OR of status bits ANDed with enables, every cycle; the code forces it low for one cycle after an error evaluate
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "tcs_map.svh"
module tcs_status_top #(
   parameter int DEPTH      = `TCS_DEST_DEPTH,
   parameter int CNT_W      = 16,
   parameter int WCNT_W     = 6,
   parameter int ALIGN_BITS = `TCS_ALIGN_BITS
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        req_valid,
   input  wire logic [CNT_W-1:0] first_dim_count,
   input  wire logic [CNT_W-1:0] second_dim_count,
   input  wire logic        source_fifo_addressing,
   input  wire logic        dest_fifo_addressing,
   input  wire logic [31:0] req_src_addr,
   input  wire logic [31:0] req_dst_addr,
   input  wire logic        src_done,
   input  wire logic        head_done,
   input  wire logic        wr_issue,
   input  wire logic        wr_status_valid,
   input  wire logic [3:0]  wr_status_code,
   input  wire logic        rd_status_valid,
   input  wire logic [3:0]  rd_status_code,
   output logic             program_set_busy,
   output logic             source_engine_busy,
   output logic             write_status_pending,
   output logic [2:0]       dest_fifo_occupancy,
   output logic             src_start,
   output logic             err_irq,
   output logic             irq
);
   localparam int OCC_W = 3;

   // true for a word-aligned offset inside the map
   function automatic logic tcs_mapped(input logic [7:0] a);
      tcs_mapped = (a[1:0] == 2'b00) && (a <= `TCS_OFS_LAST); // see RULE8
   endfunction

   tcs_pkg::tcs_prog_state_type prog_state_reg;
   logic              src_busy_reg;
   logic [WCNT_W-1:0] wcnt_reg;
   logic [3:0]        err_stat_reg;
   logic [3:0]        err_en_reg;
   logic [3:0]        err_det_reg;
   logic [2:0]        evt_stat_reg;
   logic [2:0]        evt_mask_reg;
   logic              src_start_reg;
   logic              err_irq_reg;
   logic              irq_reg;
   logic              aw_ready_reg;
   logic              w_ready_reg;
   logic              ar_ready_reg;
   logic              bvalid_reg;
   logic              rvalid_reg;
   logic [1:0]        bresp_reg;
   logic [1:0]        rresp_reg;
   logic [31:0]       rdata_reg;
   logic [7:0]        aw_addr_reg;
   logic [31:0]       w_data_reg;
   logic [3:0]        w_strb_reg;
   logic [OCC_W-1:0]  occ;
   logic              occ_full;
   logic              occ_empty;
   logic              req_bad;
   logic              req_take;
   logic              move;
   logic              pop;
   logic              bus_evt;
   logic [3:0]        bus_code;
   logic              do_wr;
   logic              do_rd;
   logic              wr_mapped;
   logic              rd_mapped;
   logic              error_reevaluate_now;
   logic [3:0]        err_set;
   logic [3:0]        err_clr;
   logic [2:0]        evt_set;
   logic [31:0]       chan_stat;
   logic [31:0]       rd_mux;

   // destination fifo occupancy
   tcs_dest_occ #(
      .DEPTH (DEPTH),
      .OCC_W (OCC_W)
   ) u_occ (
      .clk   (aclk),
      .rst_n (aresetn),
      .push  (move),
      .pop   (pop),
      .occ   (occ),
      .full  (occ_full),
      .empty (occ_empty)
   );

   // request checks: zero counts or misaligned fifo-mode addressing
   assign req_bad = (first_dim_count == '0) || (second_dim_count == '0)
      || (source_fifo_addressing && |req_src_addr[ALIGN_BITS-1:0])
      || (dest_fifo_addressing && |req_dst_addr[ALIGN_BITS-1:0])
      || ((source_fifo_addressing || dest_fifo_addressing)
          && |first_dim_count[ALIGN_BITS-1:0]); // see RULE9
   assign req_take = req_valid
      && (prog_state_reg == tcs_pkg::TCS_PS_IDLE); // see RULE7

   // admission of the held request into the destination fifo
   assign move = (prog_state_reg == tcs_pkg::TCS_PS_HELD)
      && (occ_empty // see RULE2
          || (!occ_full && !src_busy_reg)); // see RULE3 see RULE4
   assign pop = head_done && !occ_empty; // see RULE4

   // bus status: write code wins when both are nonzero
   assign bus_evt = (wr_status_valid && wr_status_code != 4'h0)
      || (rd_status_valid && rd_status_code != 4'h0);
   assign bus_code = (wr_status_valid && wr_status_code != 4'h0)
      ? wr_status_code : rd_status_code;

   // bus transactions that fire this cycle
   assign do_wr = !aw_ready_reg && !w_ready_reg && !bvalid_reg;
   assign do_rd = s_axi_arvalid && ar_ready_reg;
   assign wr_mapped = tcs_mapped(aw_addr_reg);
   assign rd_mapped = tcs_mapped(s_axi_araddr);
   assign error_reevaluate_now = do_wr && (aw_addr_reg == `TCS_OFS_ERR_CMD)
      && w_strb_reg[0] && w_data_reg[`TCS_CMD_ERROR_REEVALUATE_BIT]
      && |err_stat_reg; // see RULE14

   // error set and clear terms, bit 1 never set
   always_comb begin
      err_set = 4'h0;
      err_set[`TCS_ES_ADDR_BIT] = (do_wr && !wr_mapped)
         || (do_rd && !rd_mapped); // see RULE8
      err_set[`TCS_ES_REQ_BIT] = req_take && req_bad; // see RULE9
      err_set[`TCS_ES_BUS_BIT] = bus_evt; // see RULE10
      err_clr = 4'h0;
      if (do_wr && aw_addr_reg == `TCS_OFS_ERR_CLR && w_strb_reg[0]) begin
         err_clr = w_data_reg[3:0] & `TCS_ES_MASK; // see RULE13
      end
   end

   // program set state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prog_state_reg <= tcs_pkg::TCS_PS_IDLE;
      end else begin
         case (prog_state_reg)
            tcs_pkg::TCS_PS_IDLE: begin
               if (req_take && !req_bad) begin
                  prog_state_reg <= tcs_pkg::TCS_PS_HELD; // see RULE7
               end
            end
            tcs_pkg::TCS_PS_HELD: begin
               if (move) begin
                  prog_state_reg <= tcs_pkg::TCS_PS_IDLE; // see RULE7
               end
            end
            default: prog_state_reg <= tcs_pkg::TCS_PS_IDLE;
         endcase
      end
   end

   // source engine busy from admission until its done strobe
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         src_busy_reg  <= 1'b0;
         src_start_reg <= 1'b0;
      end else begin
         src_start_reg <= move;
         if (move) begin
            src_busy_reg <= 1'b1; // see RULE6
         end else if (src_done) begin
            src_busy_reg <= 1'b0; // see RULE6
         end
      end
   end

   // outstanding write commands awaiting their status
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wcnt_reg <= '0;
      end else if (wr_issue && !wr_status_valid) begin
         wcnt_reg <= wcnt_reg + WCNT_W'(1); // see RULE5
      end else if (wr_status_valid && !wr_issue && wcnt_reg != '0) begin
         wcnt_reg <= wcnt_reg - WCNT_W'(1); // see RULE5
      end
   end

   // error status and details, set wins over clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         err_stat_reg <= 4'h0;
         err_det_reg  <= 4'h0;
      end else begin
         err_stat_reg <= (err_stat_reg & ~err_clr) | err_set; // see RULE12
         if (bus_evt) begin
            err_det_reg <= bus_code; // see RULE10
         end else if (err_clr[`TCS_ES_BUS_BIT]) begin
            err_det_reg <= 4'h0; // see RULE13
         end
      end
   end

   // error enable and event mask registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         err_en_reg   <= `TCS_ERR_EN_RST;
         evt_mask_reg <= `TCS_EVT_MASK_RST;
      end else if (do_wr && w_strb_reg[0]) begin
         if (aw_addr_reg == `TCS_OFS_ERR_EN) begin
            err_en_reg <= w_data_reg[3:0] & `TCS_ES_MASK; // see RULE12
         end
         if (aw_addr_reg == `TCS_OFS_EVT_MASK) begin
            evt_mask_reg <= w_data_reg[2:0];
         end
      end
   end

   // error line, dropped for one cycle on evaluate to make a new edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         err_irq_reg <= 1'b0;
      end else if (error_reevaluate_now) begin
         err_irq_reg <= 1'b0; // see RULE14
      end else begin
         err_irq_reg <= |(err_stat_reg & err_en_reg); // see RULE11 see RULE16
      end
   end

   // sticky events cleared by reading them, set wins
   assign evt_set = {|err_set, pop, move};
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         evt_stat_reg <= 3'h0;
         irq_reg      <= 1'b0;
      end else begin
         irq_reg <= |(evt_stat_reg & evt_mask_reg);
         if (do_rd && s_axi_araddr == `TCS_OFS_EVT_STAT) begin
            evt_stat_reg <= evt_set;
         end else begin
            evt_stat_reg <= evt_stat_reg | evt_set;
         end
      end
   end

   // channel status word
   always_comb begin
      chan_stat = 32'h0000_0000;
      chan_stat[`TCS_CS_PROG_BIT] = (prog_state_reg
         == tcs_pkg::TCS_PS_HELD); // see RULE7
      chan_stat[`TCS_CS_SRC_BIT] = src_busy_reg; // see RULE6
      chan_stat[`TCS_CS_WSP_BIT] = (wcnt_reg != '0); // see RULE5
      chan_stat[`TCS_CS_OCC_LSB +: OCC_W] = occ; // see RULE15
      chan_stat[`TCS_CS_ONE_BIT] = 1'b1;
   end

   // read data selection
   always_comb begin
      case (s_axi_araddr)
         `TCS_OFS_CHAN_STAT: rd_mux = chan_stat;
         `TCS_OFS_ERR_STAT:  rd_mux = {28'h0, err_stat_reg}; // see RULE12
         `TCS_OFS_ERR_EN:    rd_mux = {28'h0, err_en_reg};
         `TCS_OFS_ERR_DET:   rd_mux = {28'h0, err_det_reg};
         `TCS_OFS_EVT_STAT:  rd_mux = {29'h0, evt_stat_reg};
         `TCS_OFS_EVT_MASK:  rd_mux = {29'h0, evt_mask_reg};
         default:            rd_mux = 32'h0000_0000;
      endcase
   end

   // write address and data capture, response after both
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_ready_reg <= 1'b1;
         w_ready_reg  <= 1'b1;
         bvalid_reg   <= 1'b0;
         bresp_reg    <= tcs_pkg::TCS_RESP_OKAY;
         aw_addr_reg  <= 8'h00;
         w_data_reg   <= 32'h0000_0000;
         w_strb_reg   <= 4'h0;
      end else begin
         if (s_axi_awvalid && aw_ready_reg) begin
            aw_ready_reg <= 1'b0;
            aw_addr_reg  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && w_ready_reg) begin
            w_ready_reg <= 1'b0;
            w_data_reg  <= s_axi_wdata;
            w_strb_reg  <= s_axi_wstrb;
         end
         if (do_wr) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_mapped ? tcs_pkg::TCS_RESP_OKAY
                                    : tcs_pkg::TCS_RESP_SLVERR;
         end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg   <= 1'b0;
            aw_ready_reg <= 1'b1;
            w_ready_reg  <= 1'b1;
         end
      end
   end

   // read channel, one outstanding read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ar_ready_reg <= 1'b1;
         rvalid_reg   <= 1'b0;
         rresp_reg    <= tcs_pkg::TCS_RESP_OKAY;
         rdata_reg    <= 32'h0000_0000;
      end else if (do_rd) begin
         ar_ready_reg <= 1'b0;
         rvalid_reg   <= 1'b1;
         rdata_reg    <= rd_mux;
         rresp_reg    <= rd_mapped ? tcs_pkg::TCS_RESP_OKAY
                                   : tcs_pkg::TCS_RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_reg   <= 1'b0;
         ar_ready_reg <= 1'b1;
      end
   end

   // outputs straight from flip-flops, write_status_pending through a nonzero compare of wcnt_reg
   assign s_axi_awready        = aw_ready_reg;
   assign s_axi_wready         = w_ready_reg;
   assign s_axi_bvalid         = bvalid_reg;
   assign s_axi_bresp          = bresp_reg;
   assign s_axi_arready        = ar_ready_reg;
   assign s_axi_rvalid         = rvalid_reg;
   assign s_axi_rdata          = rdata_reg;
   assign s_axi_rresp          = rresp_reg;
   assign program_set_busy     = (prog_state_reg == tcs_pkg::TCS_PS_HELD);
   assign source_engine_busy   = src_busy_reg;
   assign write_status_pending = (wcnt_reg != '0);
   assign dest_fifo_occupancy  = occ;
   assign src_start            = src_start_reg;
   assign err_irq              = err_irq_reg;
   assign irq                  = irq_reg;

   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   AST_OCC_MAX: assert property (occ <= OCC_W'(DEPTH)) // see RULE1
      else $error("occupancy above depth");
   AST_EMPTY_MOVE: assert property ( // see RULE2
      program_set_busy && occ == '0 |=> !program_set_busy && occ == 3'd1)
      else $error("request not moved into empty fifo");
   AST_MID_WAIT: assert property ( // see RULE3
      program_set_busy && occ != '0 && src_busy_reg |=> program_set_busy)
      else $error("request moved while source busy");
   AST_FULL_HOLD: assert property ( // see RULE4
      occ_full && !head_done |=> occ_full)
      else $error("full fifo left without completion");
   AST_WSP: assert property ( // see RULE5
      wr_issue && !wr_status_valid |=> write_status_pending)
      else $error("write pending not shown");
   AST_SRC_IDLE: assert property ( // see RULE6
      src_done && !move |=> !source_engine_busy)
      else $error("source busy after done");
   AST_PROG_BUSY: assert property ( // see RULE7
      program_set_busy && !move |=> program_set_busy)
      else $error("program set released early");
   AST_ADDR_FAULT: assert property ( // see RULE8
      do_rd && !rd_mapped |=> err_stat_reg[`TCS_ES_ADDR_BIT] && s_axi_rvalid)
      else $error("unmapped read not flagged");
   AST_REQ_FAULT: assert property ( // see RULE9
      req_take && req_bad |=> err_stat_reg[`TCS_ES_REQ_BIT]
      && !program_set_busy)
      else $error("bad request not flagged");
   AST_BUS_FAULT: assert property ( // see RULE10
      bus_evt |=> err_stat_reg[`TCS_ES_BUS_BIT] && err_det_reg != 4'h0)
      else $error("bus error not recorded");
   AST_ERR_LINE: assert property ( // see RULE16
      ##1 err_irq == $past(|(err_stat_reg & err_en_reg) && !error_reevaluate_now))
      else $error("error line mismatch");
   AST_RSV_ZERO: assert property ( // see RULE12
      err_stat_reg[1] == 1'b0 && err_en_reg[1] == 1'b0)
      else $error("reserved error bit set");
   AST_CLR_BUS: assert property ( // see RULE13
      err_clr[`TCS_ES_BUS_BIT] && !bus_evt
      |=> !err_stat_reg[`TCS_ES_BUS_BIT] && err_det_reg == 4'h0)
      else $error("bus error not cleared");
   AST_ERROR_REEVALUATE: assert property ( // see RULE14
      error_reevaluate_now && !$past(error_reevaluate_now) && |(err_stat_reg & err_en_reg)
      && err_clr == 4'h0 |=> !err_irq ##1 err_irq)
      else $error("evaluate did not pulse error line");

   CVR_FULL: cover property (occ_full && program_set_busy);
   CVR_REQ_FAULT: cover property (req_take && req_bad);
   CVR_ERR_IRQ: cover property ($rose(err_irq));
   CVR_ERROR_REEVALUATE: cover property (error_reevaluate_now ##2 err_irq);
endmodule // tcs_status_top

//--- tb/tb.sv
// self-checking bench of the transfer status block
// assumes the channel model stands in for the request side
`timescale 1ns/1ns
module tb;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, seed = 32'h0, lf = 32'h1721C965;
   logic [3:0]  s_axi_wstrb = 4'hF, wr_status_code = 4'h0;
   logic [3:0]  rd_status_code = 4'h0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0, head_done = 1'b0, wr_issue = 1'b0;
   logic        wr_status_valid = 1'b0, rd_status_valid = 1'b0;
   logic        send = 1'b0, bad = 1'b0, irq_q = 1'b0;
   logic [7:0]  dly = 8'hC8;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, req_valid, src_done, src_start, err_irq, irq;
   logic        source_fifo_addressing, dest_fifo_addressing;
   logic        program_set_busy, source_engine_busy, write_status_pending;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [2:0]  dest_fifo_occupancy;
   logic [15:0] first_dim_count, second_dim_count;
   logic [31:0] s_axi_rdata, req_src_addr, req_dst_addr;
   logic [33:0] exq[$];
   int          err_total = 0, n_checks = 0, drops = 0;

   tcs_status_top u_tcs_status_top (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .req_valid,
      .first_dim_count, .second_dim_count, .source_fifo_addressing,
      .dest_fifo_addressing, .req_src_addr, .req_dst_addr, .src_done,
      .head_done, .wr_issue, .wr_status_valid, .wr_status_code,
      .rd_status_valid, .rd_status_code, .program_set_busy,
      .source_engine_busy, .write_status_pending, .dest_fifo_occupancy,
      .src_start, .err_irq, .irq);
   tcs_chan_model u_tcs_chan_model (.aclk, .aresetn, .send, .bad, .seed,
      .dly, .program_set_busy, .src_start, .req_valid, .first_dim_count,
      .second_dim_count, .source_fifo_addressing, .dest_fifo_addressing,
      .req_src_addr, .req_dst_addr, .src_done);

   always #5 aclk = ~aclk;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic close_out();
      if (err_total == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [33:0] v, input logic [33:0] e);
      n_checks++;
      if (v !== e) begin
         err_total++;
         $display("unexpected %0t got %h want %h", $time, v, e);
      end
   endtask
   task automatic tick(inout int n);
      @(posedge aclk);
      n++;
      if (n > 400) begin
         err_total++;
         $display("unexpected %0t wait ran out", $time);
         close_out();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      exq.push_back(34'h0);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do tick(n); while (s_axi_awready !== 1'b1 || s_axi_wready !== 1'b1);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do tick(n); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      int n;
      n = 0;
      exq.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do tick(n); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do tick(n); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic snd();
      send <= 1'b1;
      seed <= lf;
      lf = lfsr(lf);
      @(posedge aclk);
      send <= 1'b0;
      repeat (8) @(posedge aclk);
   endtask

   // compare bus answers with the oldest note, count error line drops
   always @(posedge aclk) begin
      irq_q <= err_irq;
      if (irq_q && !err_irq) drops <= drops + 1;
      if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready))
         if (exq.size() == 0) chk(34'h0, 34'h3FFFFFFFF);
         else chk(s_axi_rvalid ? {s_axi_rresp, s_axi_rdata}
                               : {s_axi_bresp, 32'h0}, exq.pop_front());
   end

   // main sequence
   initial begin
      int n;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(8'h00, 34'h100);
      rd(8'h04, 34'h0);
      wr(8'h08, 32'hFFFFFFFF);
      rd(8'h08, 34'hD);
      rd(8'h20, {tcs_pkg::TCS_RESP_SLVERR, 32'h0});
      rd(8'h04, 34'h8);
      chk(err_irq, 34'h1);
      wr(8'h14, 32'h1);
      repeat (3) @(posedge aclk);
      chk(34'(drops), 34'h1);
      chk(err_irq, 34'h1);
      wr(8'h08, 32'h4);
      repeat (3) @(posedge aclk);
      chk(err_irq, 34'h0);
      wr(8'h0C, 32'h8);
      bad <= 1'b1;
      snd();
      bad <= 1'b0;
      rd(8'h04, 34'h4);
      chk(err_irq, 34'h1);
      wr(8'h0C, 32'h4);
      rd(8'h18, 34'h4);
      snd();
      rd(8'h00, 34'h112);
      chk(irq, 34'h0);
      wr(8'h1C, 32'h7);
      chk(irq, 34'h1);
      rd(8'h18, 34'h1);
      repeat (2) @(posedge aclk);
      chk(irq, 34'h0);
      snd();
      rd(8'h00, 34'h113);
      dly <= 8'h03;
      n = 0;
      while (program_set_busy !== 1'b0) tick(n);
      repeat (8) @(posedge aclk);
      rd(8'h00, 34'h120);
      repeat (3) snd();
      rd(8'h00, 34'h141);
      chk(dest_fifo_occupancy, 34'h4);
      chk(program_set_busy, 34'h1);
      head_done <= 1'b1;
      @(posedge aclk);
      head_done <= 1'b0;
      repeat (8) @(posedge aclk);
      rd(8'h00, 34'h140);
      head_done <= 1'b1;
      repeat (4) @(posedge aclk);
      head_done <= 1'b0;
      rd(8'h00, 34'h100);
      wr_issue <= 1'b1;
      repeat (2) @(posedge aclk);
      wr_issue <= 1'b0;
      wr_status_valid <= 1'b1;
      @(posedge aclk);
      wr_status_valid <= 1'b0;
      rd(8'h00, 34'h104);
      rd_status_code <= 4'h3;
      rd_status_valid <= 1'b1;
      @(posedge aclk);
      rd_status_valid <= 1'b0;
      rd(8'h10, 34'h3);
      wr_status_code <= 4'h9;
      wr_status_valid <= 1'b1;
      @(posedge aclk);
      wr_status_valid <= 1'b0;
      rd(8'h00, 34'h100);
      rd(8'h04, 34'h1);
      rd(8'h10, 34'h9);
      wr(8'h0C, 32'h1);
      rd(8'h04, 34'h0);
      rd(8'h10, 34'h0);
      close_out();
   end
endmodule // tb

//--- tb/tcs_chan_model.sv
// request side and source engine stand-in for the status block
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ns
module tcs_chan_model (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        send,
   input  wire logic        bad,
   input  wire logic [31:0] seed,
   input  wire logic [7:0]  dly,
   input  wire logic        program_set_busy,
   input  wire logic        src_start,
   output logic             req_valid,
   output logic [15:0]      first_dim_count,
   output logic [15:0]      second_dim_count,
   output logic             source_fifo_addressing,
   output logic             dest_fifo_addressing,
   output logic [31:0]      req_src_addr,
   output logic [31:0]      req_dst_addr,
   output logic             src_done
);
   logic        pend;
   logic [7:0]  cnt;
   logic [15:0] fc;
   // payload; outside a request first count and fifo flags inverted, other fields replaced
   assign fc = bad ? 16'h0000 : ({seed[10:0], 5'h00} | 16'h0020);
   assign first_dim_count = req_valid ? fc : ~fc;
   assign second_dim_count = req_valid ? {seed[31:17], 1'b1} : 16'hFFFE;
   assign source_fifo_addressing = req_valid ~^ seed[16];
   assign dest_fifo_addressing = req_valid ~^ seed[17];
   assign req_src_addr = req_valid ? {seed[26:0], 5'h00} : ~seed;
   assign req_dst_addr = req_valid ? {seed[31:5], 5'h00} : seed;
   // offer one request only while the program set is free
   always @(posedge aclk) begin
      if (!aresetn) begin
         req_valid <= 1'b0;
         pend <= 1'b0;
      end else if (req_valid) begin
         req_valid <= 1'b0;
         pend <= send;
      end else begin
         pend <= pend | send;
         req_valid <= (pend | send) & ~program_set_busy;
      end
   end
   // source engine finishes dly cycles after each start
   always @(posedge aclk) begin
      src_done <= 1'b0;
      if (!aresetn) cnt <= 8'h00;
      else if (src_start) cnt <= dly;
      else if (cnt == 8'h01) begin
         cnt <= 8'h00;
         src_done <= 1'b1;
      end else if (cnt != 8'h00) cnt <= cnt - 8'h01;
   end
endmodule // tcs_chan_model
